// ### rtl/dacfg_defines.svh
/*
 * Offsets, field positions, reset values and cycle counts of the DRAM area
 * and parity configuration block.
 * Assumes inclusion by bare name from rtl/ sources.
 */
`ifndef DACFG_DEFINES_SVH
`define DACFG_DEFINES_SVH

// =====================================================================
// register indices, byte address is four times the index
`define DACFG_IDX_DCR 32'h05ffffa8
`define DACFG_IDX_PCR 32'h05ffffaa
`define DACFG_IDX_IRQ_STAT 32'h05ffffc0
`define DACFG_IDX_IRQ_CLR 32'h05ffffc1
`define DACFG_IDX_IRQ_EN 32'h05ffffc2

// =====================================================================
// dram area control fields
`define DACFG_DCR_STROBE_SYS 15
`define DACFG_DCR_ROW_HOLD 14
`define DACFG_DCR_PRE_LEN 13
`define DACFG_DCR_BURST 12
`define DACFG_DCR_DUTY 11
`define DACFG_DCR_MUX 10
`define DACFG_DCR_SHIFT_HI 9
`define DACFG_DCR_SHIFT_LO 8
`define DACFG_DCR_RST 16'h0000
`define DACFG_DCR_WMASK 16'hff00

// =====================================================================
// parity control fields
`define DACFG_PCR_ERR 15
`define DACFG_PCR_FORCE 14
`define DACFG_PCR_POL 13
`define DACFG_PCR_CHK_HI 12
`define DACFG_PCR_CHK_LO 11
`define DACFG_PCR_RST 4'h0

// =====================================================================
// interrupt bits
`define DACFG_IRQ_PERR 0
`define DACFG_IRQ_DONE 1
`define DACFG_IRQ_W 2

// =====================================================================
// shift counts and cycle counts
`define DACFG_SHIFT_8 4'h8
`define DACFG_SHIFT_9 4'h9
`define DACFG_SHIFT_10 4'ha
`define DACFG_CHK_OFF 2'h0
`define DACFG_CHK_DRAM 2'h1
`define DACFG_CHK_AREA2 2'h2
`define DACFG_COL_PERIOD 20
`define DACFG_HIGH_50 10
`define DACFG_HIGH_35 7
`define DACFG_PRE_SHORT 8'h00
`define DACFG_PRE_LONG 8'h01

`endif

// ### rtl/dacfg_pkg.sv
/*
 * Types of the DRAM area and parity configuration block: states,
 * access request and DRAM pin bundle.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
`default_nettype none

package dacfg_pkg;
    typedef enum logic [2:0] {
        DACFG_ST_IDLE = 3'b000,
        DACFG_ST_PRE = 3'b001,
        DACFG_ST_ROW = 3'b010,
        DACFG_ST_COLL = 3'b011,
        DACFG_ST_COLH = 3'b100
    } dacfg_state_t;

    typedef struct packed {
        logic [27:0] addr;
        logic write;
        logic lane_hi;
        logic lane_lo;
        logic area2;
        logic [15:0] wdata;
    } dacfg_req_t;

    typedef struct packed {
        logic row_strobe_n;
        logic column_strobe_upper_n;
        logic column_strobe_lower_n;
        logic write_strobe_upper_n;
        logic write_strobe_lower_n;
        logic [27:0] addr;
        logic [15:0] dq_out;
        logic dq_oe;
        logic par_out;
        logic par_oe;
    } dacfg_pins_t;
endpackage

`default_nettype wire

// ### rtl/dacfg_parity.sv
/*
 * Parity bit of a data word, even or odd.
 * Assumes a purely combinational use.
 */
`default_nettype none

module dacfg_parity #(
    parameter int WIDTH = 16
) (
    input wire logic [WIDTH-1:0] data,
    input wire logic odd,
    output logic par
);
    assign par = (^data) ^ odd;
endmodule

`default_nettype wire

// ### rtl/dacfg_top.sv
/*
 * DRAM area configuration with parity generate and check, an access
 * sequencer for the DRAM pins and an Avalon-MM register slave.
 * Assumes DRAM pins are sampled externally-timed, one clock, sync reset.
 */
`include "dacfg_defines.svh"
`default_nettype none

module dacfg_top
    import dacfg_pkg::*;
#(
    parameter int COL_PERIOD = `DACFG_COL_PERIOD,
    parameter int HIGH_50 = `DACFG_HIGH_50,
    parameter int HIGH_35 = `DACFG_HIGH_35
) (
    input wire logic REF_CLK,
    input wire logic RST,
    input wire logic [31:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    input wire logic [3:0] AVS_BYTEENABLE,
    output logic [31:0] AVS_READDATA,
    output logic AVS_WAITREQUEST,
    output logic IRQ,
    input wire dacfg_req_t ACC_REQ,
    input wire logic ACC_VALID,
    output logic ACC_READY,
    output logic ACC_DONE,
    output logic [15:0] ACC_RDATA,
    output dacfg_pins_t DRAM_PINS,
    input wire logic [15:0] DRAM_DQ_IN,
    input wire logic DRAM_PAR_IN
);
    localparam logic [31:0] ADR_DCR = `DACFG_IDX_DCR << 2;
    localparam logic [31:0] ADR_PCR = `DACFG_IDX_PCR << 2;
    localparam logic [31:0] ADR_STAT = `DACFG_IDX_IRQ_STAT << 2;
    localparam logic [31:0] ADR_CLR = `DACFG_IDX_IRQ_CLR << 2;
    localparam logic [31:0] ADR_EN = `DACFG_IDX_IRQ_EN << 2;
    localparam logic [15:0] DCR_WMASK = `DACFG_DCR_WMASK;

    // =====================================================================
    // state
    logic [15:0] dcr_r;
    logic [3:0] pcr_ctl_r;
    logic perr_r, perr_seen_r;
    logic [`DACFG_IRQ_W-1:0] irq_stat_r, irq_en_r;
    logic wait_r, irq_r, ready_r, done_r;
    logic [31:0] readdata_r;
    logic [15:0] rdata_r;
    logic [15:0] dq_s1_r, dq_s2_r;
    logic par_s1_r, par_s2_r;
    dacfg_state_t state_r, state_nxt;
    logic [7:0] cnt_r, cnt_nxt;
    logic pend_row_r, pend_row_nxt;
    logic row_open_r, row_open_nxt;
    logic [27:0] open_addr_r, open_addr_nxt;
    dacfg_req_t cur_r, cur_nxt;
    dacfg_pins_t pins_r, pins_nxt;

    // =====================================================================
    // bus decode
    wire sel_dcr = (AVS_ADDRESS == ADR_DCR);
    wire sel_pcr = (AVS_ADDRESS == ADR_PCR);
    wire sel_stat = (AVS_ADDRESS == ADR_STAT);
    wire sel_clr = (AVS_ADDRESS == ADR_CLR);
    wire sel_en = (AVS_ADDRESS == ADR_EN);
    wire bus_req = AVS_READ | AVS_WRITE;
    wire wr_fire = AVS_WRITE & ~wait_r;
    wire rd_fire = AVS_READ & ~wait_r;
    wire [15:0] wmask = {{8{AVS_BYTEENABLE[1]}}, {8{AVS_BYTEENABLE[0]}}};
    wire [15:0] dcr_wval = (dcr_r & ~wmask) | (AVS_WRITEDATA[15:0] & wmask & DCR_WMASK);
    wire [3:0] pcr_wval = AVS_BYTEENABLE[1] ? AVS_WRITEDATA[`DACFG_PCR_FORCE:`DACFG_PCR_CHK_LO] : pcr_ctl_r;
    wire [15:0] pcr_view = {perr_r, pcr_ctl_r, 11'h0};
    wire [31:0] rd_mux = sel_dcr ? {16'h0000, dcr_r} :
                         sel_pcr ? {16'h0000, pcr_view} :
                         sel_stat ? {30'h0000000, irq_stat_r} :
                         sel_en ? {30'h0000000, irq_en_r} : 32'h00000000;

    // =====================================================================
    // configuration fields
    wire strobe_sys = dcr_r[`DACFG_DCR_STROBE_SYS];
    wire row_hold = dcr_r[`DACFG_DCR_ROW_HOLD];
    wire pre_long = dcr_r[`DACFG_DCR_PRE_LEN];
    wire burst = dcr_r[`DACFG_DCR_BURST];
    wire duty35 = dcr_r[`DACFG_DCR_DUTY];
    wire mux_en = dcr_r[`DACFG_DCR_MUX];
    wire [1:0] shift_code = dcr_r[`DACFG_DCR_SHIFT_HI:`DACFG_DCR_SHIFT_LO];
    wire forced = pcr_ctl_r[3];
    wire odd = pcr_ctl_r[2];
    wire [1:0] chk_code = pcr_ctl_r[1:0];
    // row shift and row compare range
    wire [3:0] row_shift = (shift_code == 2'b01) ? `DACFG_SHIFT_9 :
                           (shift_code == 2'b10) ? `DACFG_SHIFT_10 : `DACFG_SHIFT_8;
    wire [27:0] row_mask = 28'hfffffff << row_shift;
    wire page_hit = ((ACC_REQ.addr ^ open_addr_r) & row_mask) == 28'h0000000;
    wire [7:0] high_len = duty35 ? 8'(HIGH_35 - 1) : 8'(HIGH_50 - 1);
    wire [7:0] low_len = duty35 ? 8'(COL_PERIOD - HIGH_35 - 1) : 8'(COL_PERIOD - HIGH_50 - 1);
    wire [7:0] pre_len = pre_long ? `DACFG_PRE_LONG : `DACFG_PRE_SHORT;
    // parity enable by area
    wire par_en_cur = ((chk_code == `DACFG_CHK_DRAM) & ~cur_r.area2) | (chk_code == `DACFG_CHK_AREA2);
    wire par_en_nxt = ((chk_code == `DACFG_CHK_DRAM) & ~cur_nxt.area2) | (chk_code == `DACFG_CHK_AREA2);

    // =====================================================================
    // parity generate and check
    logic gen_par, exp_par;
    dacfg_parity #(.WIDTH(16)) u_gen (
        .data(cur_nxt.wdata),
        .odd(odd),
        .par(gen_par)
    );
    dacfg_parity #(.WIDTH(16)) u_chk (
        .data(dq_s2_r),
        .odd(odd),
        .par(exp_par)
    );
    wire col_end = (state_r == DACFG_ST_COLL) && (cnt_r == 8'h00);
    wire acc_end = (state_r == DACFG_ST_COLH) && (cnt_r == 8'h00);
    // mismatch on an enabled read
    wire perr_set = col_end & par_en_cur & ~cur_r.write & (par_s2_r != exp_par);
    // clear only after the flag was read as one
    wire perr_clr = wr_fire & sel_pcr & AVS_BYTEENABLE[1] & ~AVS_WRITEDATA[`DACFG_PCR_ERR] & perr_seen_r;
    wire perr_nxt = perr_set | (perr_r & ~perr_clr);
    wire [`DACFG_IRQ_W-1:0] irq_ev = {acc_end, perr_set};
    wire [`DACFG_IRQ_W-1:0] irq_clr = (wr_fire & sel_clr) ? AVS_WRITEDATA[`DACFG_IRQ_W-1:0] : 2'b00;
    wire [`DACFG_IRQ_W-1:0] irq_stat_nxt = irq_ev | (irq_stat_r & ~irq_clr);
    wire [`DACFG_IRQ_W-1:0] irq_en_nxt = (wr_fire & sel_en) ? AVS_WRITEDATA[`DACFG_IRQ_W-1:0] : irq_en_r;

    // =====================================================================
    // access sequencer
    wire take = (state_r == DACFG_ST_IDLE) & ready_r & ACC_VALID;
    // row kept open while waiting, or for a pending page hit
    wire leave_open = row_hold | (burst & ACC_VALID & page_hit);

    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        pend_row_nxt = pend_row_r;
        row_open_nxt = row_open_r;
        open_addr_nxt = open_addr_r;
        cur_nxt = cur_r;
        case (state_r)
            DACFG_ST_IDLE: begin
                if (take) begin
                    cur_nxt = ACC_REQ;
                    if (row_open_r && burst && page_hit) begin
                        state_nxt = DACFG_ST_COLL;
                        cnt_nxt = low_len;
                    end else if (row_open_r) begin
                        state_nxt = DACFG_ST_PRE;
                        cnt_nxt = pre_len;
                        pend_row_nxt = 1'b1;
                        row_open_nxt = 1'b0;
                    end else begin
                        state_nxt = DACFG_ST_ROW;
                    end
                end
            end
            DACFG_ST_ROW: begin
                state_nxt = DACFG_ST_COLL;
                cnt_nxt = low_len;
                row_open_nxt = 1'b1;
                open_addr_nxt = cur_r.addr;
            end
            DACFG_ST_COLL: begin
                if (cnt_r == 8'h00) begin
                    state_nxt = DACFG_ST_COLH;
                    cnt_nxt = high_len;
                end else begin
                    cnt_nxt = cnt_r - 8'h01;
                end
            end
            DACFG_ST_COLH: begin
                if (cnt_r != 8'h00) begin
                    cnt_nxt = cnt_r - 8'h01;
                end else if (leave_open) begin
                    state_nxt = DACFG_ST_IDLE;
                end else begin
                    state_nxt = DACFG_ST_PRE;
                    cnt_nxt = pre_len;
                    pend_row_nxt = 1'b0;
                    row_open_nxt = 1'b0;
                end
            end
            DACFG_ST_PRE: begin
                if (cnt_r != 8'h00) begin
                    cnt_nxt = cnt_r - 8'h01;
                end else if (pend_row_r) begin
                    state_nxt = DACFG_ST_ROW;
                end else begin
                    state_nxt = DACFG_ST_IDLE;
                end
            end
            default: begin
                state_nxt = DACFG_ST_IDLE;
            end
        endcase
    end

    // =====================================================================
    // pin values for the next state
    wire nxt_col = (state_nxt == DACFG_ST_COLL);
    wire nxt_busy = (state_nxt == DACFG_ST_ROW) | nxt_col | (state_nxt == DACFG_ST_COLH);
    wire nxt_wr = nxt_col & cur_nxt.write;

    always_comb begin
        pins_nxt.row_strobe_n = ~(nxt_busy | ((state_nxt == DACFG_ST_IDLE) & row_open_nxt));
        // strobe arrangement
        pins_nxt.column_strobe_upper_n = ~(nxt_col & ~strobe_sys & cur_nxt.lane_hi);
        pins_nxt.column_strobe_lower_n = ~(nxt_col & (strobe_sys | cur_nxt.lane_lo));
        pins_nxt.write_strobe_upper_n = ~(nxt_wr & strobe_sys & cur_nxt.lane_hi);
        pins_nxt.write_strobe_lower_n = ~(nxt_wr & (~strobe_sys | cur_nxt.lane_lo));
        // row on the pins shifted when multiplexed
        pins_nxt.addr = ((state_nxt == DACFG_ST_ROW) & mux_en) ? (cur_nxt.addr >> row_shift) : cur_nxt.addr;
        pins_nxt.dq_out = cur_nxt.wdata;
        pins_nxt.dq_oe = nxt_busy & cur_nxt.write;
        pins_nxt.par_out = forced | gen_par;
        pins_nxt.par_oe = nxt_busy & cur_nxt.write & (forced | par_en_nxt);
    end

    // =====================================================================
    // flops
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            dcr_r <= `DACFG_DCR_RST;
            pcr_ctl_r <= `DACFG_PCR_RST;
            perr_r <= 1'b0;
            perr_seen_r <= 1'b0;
            irq_stat_r <= 2'b00;
            irq_en_r <= 2'b00;
            irq_r <= 1'b0;
            wait_r <= 1'b1;
            readdata_r <= 32'h00000000;
        end else begin
            if (wr_fire && sel_dcr) begin
                dcr_r <= dcr_wval;
            end
            if (wr_fire && sel_pcr) begin
                pcr_ctl_r <= pcr_wval;
            end
            perr_r <= perr_nxt;
            if (perr_clr) begin
                perr_seen_r <= 1'b0;
            end else if (rd_fire && sel_pcr && readdata_r[`DACFG_PCR_ERR]) begin
                perr_seen_r <= 1'b1;
            end
            irq_stat_r <= irq_stat_nxt;
            irq_en_r <= irq_en_nxt;
            irq_r <= |(irq_stat_nxt & irq_en_nxt);
            wait_r <= ~(bus_req & wait_r);
            if (bus_req && wait_r) begin
                readdata_r <= rd_mux;
            end
        end
    end

    always_ff @(posedge REF_CLK) begin
        dq_s1_r <= DRAM_DQ_IN;
        dq_s2_r <= dq_s1_r;
        par_s1_r <= DRAM_PAR_IN;
        par_s2_r <= par_s1_r;
    end

    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            state_r <= DACFG_ST_IDLE;
            cnt_r <= 8'h00;
            pend_row_r <= 1'b0;
            row_open_r <= 1'b0;
            open_addr_r <= 28'h0000000;
            cur_r <= '0;
            pins_r <= '1;
            pins_r.dq_out <= 16'h0000;
            pins_r.addr <= 28'h0000000;
            pins_r.dq_oe <= 1'b0;
            pins_r.par_out <= 1'b0;
            pins_r.par_oe <= 1'b0;
            ready_r <= 1'b0;
            done_r <= 1'b0;
            rdata_r <= 16'h0000;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            pend_row_r <= pend_row_nxt;
            row_open_r <= row_open_nxt;
            open_addr_r <= open_addr_nxt;
            cur_r <= cur_nxt;
            pins_r <= pins_nxt;
            ready_r <= (state_nxt == DACFG_ST_IDLE);
            done_r <= acc_end;
            if (col_end) begin
                rdata_r <= dq_s2_r;
            end
        end
    end

    assign AVS_READDATA = readdata_r;
    assign AVS_WAITREQUEST = wait_r;
    assign IRQ = irq_r;
    assign ACC_READY = ready_r;
    assign ACC_DONE = done_r;
    assign ACC_RDATA = rdata_r;
    assign DRAM_PINS = pins_r;

    // =====================================================================
    // assertions
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (RST);

    sequence s_pre_one;
        (state_r == DACFG_ST_PRE) ##1 (state_r != DACFG_ST_PRE);
    endsequence
    sequence s_pre_two;
        (state_r == DACFG_ST_PRE) [*2] ##1 (state_r != DACFG_ST_PRE);
    endsequence

    AST_TWO_CAS_NO_WRH: assert property (!$past(strobe_sys) |-> pins_r.write_strobe_upper_n)
        else $error("upper write strobe active in two column strobe system");
    AST_TWO_WE_NO_COLUMN_STROBE_UPPER: assert property ($past(strobe_sys) |-> pins_r.column_strobe_upper_n)
        else $error("upper column strobe active in two write strobe system");
    AST_ROW_HOLD: assert property (acc_end && row_hold |=> state_r == DACFG_ST_IDLE && !pins_r.row_strobe_n)
        else $error("row strobe not held low after access");
    AST_ROW_RISE: assert property (acc_end && !leave_open |=> pins_r.row_strobe_n)
        else $error("row strobe not returned high after access");
    AST_PRE_SHORT: assert property ($rose(state_r == DACFG_ST_PRE) && !$past(pre_long, 1) |-> s_pre_one)
        else $error("short precharge not one cycle");
    AST_PRE_LONG: assert property ($rose(state_r == DACFG_ST_PRE) && $past(pre_long, 1) |-> s_pre_two)
        else $error("long precharge not two cycles");
    AST_FULL_ACCESS: assert property (take && !burst |=> state_r != DACFG_ST_COLL)
        else $error("page access taken with burst off");
    AST_PAGE_HIT: assert property (take && row_open_r && burst |=> (state_r == DACFG_ST_COLL) == $past(page_hit))
        else $error("page hit decision wrong");
    AST_HIGH_WIDTH: assert property ($rose(state_r == DACFG_ST_COLH) |->
        cnt_r == ($past(duty35) ? 8'(HIGH_35 - 1) : 8'(HIGH_50 - 1)))
        else $error("column strobe high width wrong");
    AST_ROW_ADDR: assert property (state_r == DACFG_ST_ROW |->
        pins_r.addr == ($past(mux_en) ? (cur_r.addr >> $past(row_shift)) : cur_r.addr))
        else $error("row address on pins wrong");
    AST_ERR_SET: assert property (perr_set |=> perr_r ##1 (perr_r || $past(perr_clr)))
        else $error("parity error flag not set");
    AST_ERR_NEEDS_READ: assert property (perr_r && !perr_seen_r && !perr_set |=> perr_r)
        else $error("parity error flag cleared without prior read");
    AST_FORCED_HIGH: assert property (pins_r.par_oe && $past(forced) |-> pins_r.par_out)
        else $error("forced parity not high");
    AST_PAR_POLARITY: assert property (pins_r.par_oe && !$past(forced) |->
        pins_r.par_out == ((^pins_r.dq_out) ^ $past(odd)))
        else $error("generated parity polarity wrong");
    AST_CHK_OFF: assert property ($past(chk_code == `DACFG_CHK_OFF && !forced) |->
        !pins_r.par_oe && !(perr_set && chk_code == `DACFG_CHK_OFF))
        else $error("parity active with checking off");
endmodule

`default_nettype wire

// ### tb/dacfg_dram_model.sv
/*
 * DRAM partner model: a word store with a stored parity bit per word.
 * Assumes the pin bundle of dacfg_pkg, one clock, strobes active low.
 */
`default_nettype none

module dacfg_dram_model
    import dacfg_pkg::*;
(
    input wire logic clk,
    input wire dacfg_pins_t pins,
    input wire logic bad_par,
    output logic [15:0] dq,
    output logic par
);
    timeunit 1ns;
    timeprecision 1ps;
    // =====================================================================
    // store and read drive
    logic [15:0] mem [256];
    logic pmem [256];
    logic [15:0] last_r = 16'h5a5a;
    wire logic [7:0] idx = pins.addr[7:0];
    wire logic sel = !pins.column_strobe_lower_n || !pins.column_strobe_upper_n;
    wire logic wr = !pins.write_strobe_lower_n || !pins.write_strobe_upper_n;
    // undriven bus scrambles every cycle
    assign dq = (sel && !wr) ? mem[idx] : ~last_r;
    assign par = (sel && !wr) ? pmem[idx] ^ bad_par : ~last_r[0];
    always @(posedge clk) begin
        last_r <= dq;
        if (sel && wr) begin
            mem[idx] <= pins.dq_out;
            pmem[idx] <= pins.par_out;
        end
    end
endmodule

`default_nettype wire

// ### tb/testbench.sv
/*
 * Self-checking bench: random register settings, DRAM writes and reads,
 * parity faults, flag and interrupt clearing.
 * Assumes dacfg_pkg, the defines header and the DRAM model.
 */
`include "dacfg_defines.svh"
`default_nettype none

module testbench
    import dacfg_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // =====================================================================
    // signals
    localparam logic [31:0] A_DCR = `DACFG_IDX_DCR << 2;
    localparam logic [31:0] A_PCR = `DACFG_IDX_PCR << 2;
    localparam logic [31:0] A_IST = `DACFG_IDX_IRQ_STAT << 2;
    localparam logic [31:0] A_ICL = `DACFG_IDX_IRQ_CLR << 2;
    localparam logic [31:0] A_IEN = `DACFG_IDX_IRQ_EN << 2;
    logic ref_clk = 1'b0, rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0, acc_valid = 1'b0, bad_par = 1'b0;
    logic [31:0] avs_address = 32'h0, avs_writedata = 32'h0, rd, r, rng = 32'hda3c, avs_readdata;
    dacfg_req_t acc_req = '0;
    dacfg_pins_t pins;
    logic avs_waitrequest, irq, acc_ready, acc_done, par_in, wpar, sp, en_p, exp_f, got_row = 1'b0;
    logic prev_row = 1'b1, cw2 = 1'b0, woe;
    logic [15:0] acc_rdata, dq_in, dram_area_control, parity_control, dat;
    logic [27:0] row_addr, aa;
    logic [1:0] ck;
    int fails = 0, total_checks = 0, lows = 0, mon_bad = 0;

    always #5 ref_clk = ~ref_clk;

    dacfg_top u_dacfg_top (.REF_CLK(ref_clk), .RST(rst), .AVS_ADDRESS(avs_address), .AVS_READ(avs_read),
        .AVS_WRITE(avs_write), .AVS_WRITEDATA(avs_writedata), .AVS_BYTEENABLE(4'hf),
        .AVS_READDATA(avs_readdata), .AVS_WAITREQUEST(avs_waitrequest), .IRQ(irq), .ACC_REQ(acc_req),
        .ACC_VALID(acc_valid), .ACC_READY(acc_ready), .ACC_DONE(acc_done), .ACC_RDATA(acc_rdata),
        .DRAM_PINS(pins), .DRAM_DQ_IN(dq_in), .DRAM_PAR_IN(par_in));
    dacfg_dram_model u_dacfg_dram_model (.clk(ref_clk), .pins(pins), .bad_par(bad_par), .dq(dq_in), .par(par_in));

    // =====================================================================
    // pin monitor
    always @(posedge ref_clk) begin
        if (pins.column_strobe_lower_n === 1'b0) lows++;
        if ((cw2 ? pins.column_strobe_upper_n : pins.write_strobe_upper_n) === 1'b0) mon_bad++;
        if (!pins.write_strobe_lower_n || !pins.write_strobe_upper_n) begin
            wpar = pins.par_out;
            woe = pins.par_oe;
        end
        if (pins.row_strobe_n === 1'b0 && prev_row) begin
            row_addr = pins.addr;
            got_row = 1'b1;
        end
        prev_row = pins.row_strobe_n;
    end

    // =====================================================================
    // helpers
    function automatic logic [31:0] nxt();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng;
    endfunction

    function automatic logic pexp(input logic [15:0] d, input logic odd);
        return ^d ^ odd;
    endfunction

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            fails++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        int n;
        n = 0;
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= !w;
        do begin
            @(posedge ref_clk);
            n++;
        end while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        chk("bus_wait", 1, n < 50);
        @(posedge ref_clk);
    endtask

    task automatic acc(input logic w, input logic [27:0] a, input logic [15:0] d, input logic ar2);
        int n;
        n = 0;
        acc_req <= '{addr: a, write: w, lane_hi: 1'b1, lane_lo: 1'b1, area2: ar2, wdata: d};
        acc_valid <= 1'b1;
        do begin
            @(posedge ref_clk);
            n++;
        end while (acc_ready !== 1'b1);
        acc_valid <= 1'b0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (acc_done !== 1'b1);
        chk("acc_wait", 1, n < 200);
    endtask

    task automatic wrap_up();
        $display("checks %0d fails %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // =====================================================================
    // main sequence
    initial begin
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        bus(0, A_DCR, 0);
        chk("dcr_rst", `DACFG_DCR_RST, rd);
        bus(0, A_PCR, 0);
        chk("pcr_rst", 32'h0, rd);
        bus(0, 32'h100, 0);
        chk("unmapped", 32'h0, rd);
        for (int i = 0; i < 12; i++) begin
            // all other fields set, all clear, then random; shift and check codes from the loop index
            r = (i == 0) ? 32'hffffffff : (i == 1) ? 32'h00000000 : nxt();
            ck = 2'(i % 3);
            dram_area_control = {r[15:10], ck, r[7:0]};
            parity_control = {1'b0, r[17:16], ck, r[10:0]};
            cw2 = dram_area_control[15];
            aa = r[27:0];
            dat = r[31:16];
            en_p = (ck == 2'h1 && !r[20]) || ck == 2'h2;
            bus(1, A_DCR, {16'h0, dram_area_control});
            bus(0, A_DCR, 0);
            chk("dcr", {16'h0, dram_area_control & `DACFG_DCR_WMASK}, rd);
            bus(1, A_PCR, {16'h0, parity_control});
            bus(0, A_PCR, 0);
            chk("pcr", {16'h0, parity_control & 16'h7800}, rd);
            bus(1, A_IEN, {31'h0, r[21]});
            lows = 0;
            mon_bad = 0;
            got_row = 1'b0;
            acc(1, aa, dat, r[20]);
            chk("col_low", `DACFG_COL_PERIOD - (dram_area_control[11] ? `DACFG_HIGH_35 : `DACFG_HIGH_50), lows);
            chk("strobes", 0, mon_bad);
            if (got_row) chk("row_addr", dram_area_control[10] ? aa >> (8 + ck) : aa, row_addr);
            sp = parity_control[14] ? 1'b1 : pexp(dat, parity_control[13]);
            if (parity_control[14] || en_p) chk("par_out", sp, wpar);
            chk("par_oe", parity_control[14] || en_p, woe);
            while (acc_ready !== 1'b1) @(posedge ref_clk);
            chk("row_idle", !dram_area_control[14], pins.row_strobe_n);
            bad_par <= r[22];
            acc(0, aa, 16'h0, r[20]);
            chk("rdata", dat, acc_rdata);
            exp_f = en_p && ((sp ^ r[22]) != pexp(dat, parity_control[13]));
            bus(0, A_PCR, 0);
            chk("pef", exp_f, rd[15]);
            bus(0, A_IST, 0);
            chk("irq_stat", exp_f, rd[0]);
            chk("irq_done", 1, rd[1]);
            chk("irq", exp_f & r[21], irq);
            bus(1, A_PCR, {16'h0, parity_control & 16'h7fff});
            bus(1, A_ICL, 32'h3);
            bus(0, A_PCR, 0);
            chk("pef_clr", 0, rd[15]);
            chk("irq_clr", 0, irq);
            bad_par <= 1'b0;
        end
        wrap_up();
    end

    initial begin
        #200000;
        fails++;
        wrap_up();
    end
endmodule

`default_nettype wire
